// *** design/pis_sequencer.sv ***
// Purpose: Priority interrupt logic and its CPU sequencer hooks.
// Assumes: Pulse and phase counts come from the CPU on the same clock.
// Notes: Request lines are pins and pass a three stage synchroniser.
//
// Contract
// - Latch request lines only from T22 to T17.
// - Lower channel number ranks higher, chainable.
// - Forward request if pending, inactive, none higher.
// - Set taken flop at T10 of end cycle.
// - Taken interrupt clears halt after halt stop.
// - Taken flop loads vector, blocks counter transfer.
// - Acknowledge in first non-end cycle, clear at T10.
// - Acknowledge makes highest pending channel active.
// - Higher request nests inside lower routine.
// - Higher request before acknowledge wins acknowledge.
// - Release pulse on indirect unconditional branch.
// - Release clears only highest active channel.
// - Skip end passes phase seven, reloads vector.
// - Acknowledge is not gated by time-share.
// - Waiting channel recognised at releasing branch end.
// - Single-step channel blocks indirect flop set.
// - Single-step channel releases immediately outside share.
`timescale 1ns/1ns
module pis_sequencer
    import pis_pkg::*;
#(
    parameter int N = pis_pkg::PIS_CHANNELS,
    parameter int VW = pis_pkg::PIS_VEC_W
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Master clear
    input wire logic i_master_clear,
    // External request pins
    input wire logic [N-1:0] i_chan_line,
    // Static configuration
    input wire logic [N-1:0] i_single_step_cfg,
    input wire logic [N*VW-1:0] i_chan_vector,
    // CPU timing and instruction state
    input wire pis_pkg::pis_timing_s i_timing,
    input wire pis_pkg::pis_instr_s i_instr,
    input wire logic i_halt_ff,
    input wire logic i_parity_err_ff,
    input wire logic i_run_sw_sig,
    // Outputs to the CPU
    output logic o_cpu_service_call,
    output logic o_int_taken,
    output logic o_halt_clear,
    output logic o_pc_xfer_inhibit,
    output logic o_vector_load,
    output logic [VW-1:0] o_vector_addr_lines,
    output logic o_force_phase_seven,
    output logic o_indirect_set_block,
    output logic o_ack_window_pulse,
    output logic o_chan_release_pulse,
    // Status
    output logic [N-1:0] o_chan_pending,
    output logic [N-1:0] o_chan_active
);
    import pis_pkg::*;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Three stages: a change counts only once stages two and three agree.
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sync3;
    logic [N-1:0] line_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            line_q <= '0;
        end else if (i_ce) begin
            sync1 <= i_chan_line;
            sync2 <= sync1;
            sync3 <= sync2;
            line_q <= (sync2 & sync3) | (line_q & (sync2 | sync3));
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [N-1:0] pending;
    logic [N-1:0] active;
    logic taken;
    logic [N-1:0] first_pending;
    logic [N-1:0] first_active;
    logic [N-1:0] service_sel;
    wire in_window = (i_timing.pulse <= PIS_T_WIN_HI) &&
                     (i_timing.pulse >= PIS_T_WIN_LO);
    wire at_take = i_timing.pulse == PIS_T_TAKE;
    wire at_xfer = i_timing.pulse == PIS_T_XFER;
    wire share = i_timing.mem_share_ff;
    wire end_bit = i_timing.end_cycle_bit;
    wire single_step_chan_hit = |(active & i_single_step_cfg);
    wire uncond_branch = (i_timing.phase == PIS_PH_ZERO) &&
                         i_instr.indirect_ff &&
                         (i_instr.opcode == PIS_OP_UNCOND_BRANCH);

    // The chain gives each channel the "none higher pending" term.
    pis_prio_chain #(
        .N(N)
    ) u_chain (
        .i_pending(pending),
        .i_active(active),
        .o_first_pending(first_pending),
        .o_first_active(first_active)
    );

    // Only the first pending channel, if it is not yet active, asks.
    // A higher channel can ask while a lower one is active.
    assign service_sel = first_pending & ~active;
    wire cpu_service_call = |service_sel;

    // Take at T10 of an end cycle; waiting channels are seen here only.
    // After a release, the next take is the branch's own end cycle.
    wire take_now = at_take && end_bit && cpu_service_call && !share;
    // Acknowledge ignores time-share on purpose.
    wire ack_window_pulse = taken && !end_bit && in_window;
    wire clear_taken = at_take && taken && !end_bit;
    // Release by indirect branch, or at once for a single-step channel.
    wire rel_branch = uncond_branch && in_window;
    wire rel_single = single_step_chan_hit && !share && end_bit &&
                      in_window;
    wire chan_release_pulse = rel_branch || rel_single;
    // The window spans six clocks; a release acts on its first clock only, so
    // one release never unwinds more than one nesting level.
    wire win_first = i_timing.pulse == PIS_T_WIN_HI;
    wire rel_now = chan_release_pulse && win_first;
    wire [N-1:0] rel_mask = rel_now ? first_active : '0;
    // Acknowledge sets the first pending channel, so a later arriving
    // higher channel takes the acknowledge instead.
    wire [N-1:0] ack_mask = ack_window_pulse ? first_pending : '0;
    wire [N-1:0] sample = in_window ? line_q : '0;

    // ------------------------------------------------------------
    // Channel flags
    // ------------------------------------------------------------
    // Set wins over release, so a fresh request is never dropped.
    wire [N-1:0] next_pending = (pending & ~rel_mask) | sample;
    wire [N-1:0] next_active = (active & ~rel_mask) | ack_mask;
    wire next_taken = take_now | (taken & ~clear_taken);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pending <= '0;
            active <= '0;
            taken <= PIS_TAKEN_RESET;
        end else if (i_ce) begin
            if (i_master_clear) begin
                pending <= '0;
                active <= '0;
                taken <= PIS_TAKEN_RESET;
            end else begin
                pending <= next_pending;
                active <= next_active;
                taken <= next_taken;
            end
        end
    end

    // ------------------------------------------------------------
    // Vector selection
    // ------------------------------------------------------------
    // Vector follows the current winner, so a phase seven reload
    // picks up a higher channel that arrived meanwhile.
    logic [VW-1:0] vec_sel;
    always_comb begin
        vec_sel = '0;
        for (int k = 0; k < N; k++) begin
            if (first_pending[k]) begin
                vec_sel = i_chan_vector[k*VW +: VW];
            end
        end
    end
    wire vec_load = taken && !share && (at_xfer ||
                    i_timing.phase == PIS_PH_SEVEN);
    logic [VW-1:0] vector_addr_lines;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            vector_addr_lines <= '0;
        end else if (i_ce && vec_load) begin
            vector_addr_lines <= vec_sel;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_cpu_service_call = cpu_service_call;
    assign o_int_taken = taken;
    // Halt from a halt instruction only, with the switch at run.
    assign o_halt_clear = taken && i_run_sw_sig && i_halt_ff &&
                          !i_parity_err_ff;
    assign o_pc_xfer_inhibit = taken && !share && at_xfer;
    assign o_vector_load = vec_load;
    assign o_vector_addr_lines = vector_addr_lines;
    assign o_force_phase_seven = take_now && i_instr.skip_taken;
    assign o_indirect_set_block = single_step_chan_hit &&
        (i_timing.phase == PIS_PH_FOUR ||
         i_timing.phase == PIS_PH_SIX);
    assign o_ack_window_pulse = ack_window_pulse;
    assign o_chan_release_pulse = chan_release_pulse;
    assign o_chan_pending = pending;
    assign o_chan_active = active;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    take_at_ten_a: assert property (i_ce && !i_master_clear && !taken &&
        at_take && end_bit && cpu_service_call && !share |=> taken)
        else $error("taken flop not set at T10");
    ack_window_a: assert property (ack_window_pulse |->
        in_window && !end_bit && taken)
        else $error("acknowledge outside window");
    clear_taken_a: assert property (i_ce && taken && clear_taken &&
        !take_now |=> !taken)
        else $error("taken flop not cleared");
    service_one_a: assert property ($onehot0(service_sel))
        else $error("more than one channel served");
    release_one_a: assert property (i_ce && !i_master_clear &&
        rel_now && |active |=>
        $countones($past(active) & ~active) == 1)
        else $error("release touched several channels");
    sample_window_a: assert property (i_ce && !i_master_clear &&
        !in_window |=> (pending & ~$past(pending)) == '0)
        else $error("pending set outside window");
    master_clear_a: assert property (i_ce && i_master_clear |=>
        pending == '0 && active == '0 && !taken)
        else $error("master clear left flags");
    single_block_a: assert property (single_step_chan_hit &&
        i_timing.phase == PIS_PH_SIX |-> o_indirect_set_block)
        else $error("indirect set not blocked");

    take_cov: cover property (take_now ##[1:60] ack_window_pulse);
    release_cov: cover property (chan_release_pulse && |active);
    nest_cov: cover property (active[N-1] && cpu_service_call);
endmodule

// *** design/pis_pkg.sv ***
// Purpose: Shared constants and carriers for the priority interrupt sequencer.
// Assumes: Pulse counter counts down from 24 to 0, phase counter 0 to 7.
// Notes: Channel count and vector width are parameters of the top module.
package pis_pkg;

    // ------------------------------------------------------------
    // Timing and decode constants
    // ------------------------------------------------------------
    localparam logic [4:0] PIS_T_WIN_HI = 5'h16;
    localparam logic [4:0] PIS_T_WIN_LO = 5'h11;
    localparam logic [4:0] PIS_T_TAKE = 5'h0a;
    localparam logic [4:0] PIS_T_XFER = 5'h09;
    localparam logic [2:0] PIS_PH_ZERO = 3'h0;
    localparam logic [2:0] PIS_PH_FOUR = 3'h4;
    localparam logic [2:0] PIS_PH_SIX = 3'h6;
    localparam logic [2:0] PIS_PH_SEVEN = 3'h7;
    localparam logic [5:0] PIS_OP_UNCOND_BRANCH = 6'h01;
    localparam int PIS_GROUP = 16;
    localparam int PIS_CHANNELS = 2;
    localparam int PIS_VEC_W = 10;
    localparam logic PIS_TAKEN_RESET = 1'b0;

    // ------------------------------------------------------------
    // Sequencer timing carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] pulse;
        logic [2:0] phase;
        logic end_cycle_bit;
        logic mem_share_ff;
    } pis_timing_s;

    // ------------------------------------------------------------
    // Decoded instruction carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] opcode;
        logic indirect_ff;
        logic skip_taken;
    } pis_instr_s;

endpackage

// *** design/pis_prio_chain.sv ***
// Purpose: Fixed priority chain over the channel flags.
// Assumes: Bit 0 is the highest priority channel.
// Notes: Purely combinational; each output has at most one bit set.
`timescale 1ns/1ns
module pis_prio_chain #(
    parameter int N = 2
) (
    // Flags in
    input wire logic [N-1:0] i_pending,
    input wire logic [N-1:0] i_active,
    // Selections out
    output logic [N-1:0] o_first_pending,
    output logic [N-1:0] o_first_active
);
    wire [N:0] pend_above;
    wire [N:0] act_above;
    assign pend_above[0] = 1'b0;
    assign act_above[0] = 1'b0;

    // ------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chain
            assign o_first_pending[g] = i_pending[g] & ~pend_above[g];
            assign o_first_active[g] = i_active[g] & ~act_above[g];
            assign pend_above[g+1] = pend_above[g] | i_pending[g];
            assign act_above[g+1] = act_above[g] | i_active[g];
        end
    endgenerate
endmodule

// *** dv/pis_cpu_model.sv ***
// Purpose: Behavioural pulse counter of the CPU sequencer.
// Assumes: One pulse time per clock, counting 24 down to 0.
// Notes: Phase, end and share levels are driven by the bench.
`timescale 1ns/1ns
module pis_cpu_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Pulse count
    output logic [4:0] o_pulse
);
    // A word time is 25 pulses, so the count wraps from 0 back to 24.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pulse <= 5'h18;
        end else if (i_ce) begin
            o_pulse <= (o_pulse == 5'h00) ? 5'h18 : o_pulse - 5'h01;
        end
    end
endmodule

// *** dv/priority_interrupt_sequencer_tb_top.sv ***
// Purpose: Self-checking bench for the interrupt sequencer.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes: Word fields change only while the pulse count is 0.
`timescale 1ns/1ns
module priority_interrupt_sequencer_tb_top;
    import pis_pkg::*;
    logic i_clk = 0;
    logic i_resetn = 0;
    logic mclr = 0;
    logic [1:0] line = 0;
    logic [1:0] ss = 0;
    logic [19:0] vec = 0;
    logic [4:0] pulse;
    logic [2:0] ph = 0;
    logic en = 0, sh = 0, ind = 0, skp = 0, halt = 0, par = 0, run = 0;
    logic [5:0] op = 0;
    pis_timing_s tm;
    pis_instr_s ins;
    logic svc, tk, hc, blk;
    logic [1:0] pend, act;
    logic [9:0] vl;
    int failures = 0;
    int n_tests = 0;
    assign tm = {pulse, ph, en, sh};
    assign ins = {op, ind, skp};
    always #10 i_clk = ~i_clk;

    pis_cpu_model u_cpu (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_ce(1'b1), .o_pulse(pulse));
    pis_sequencer #(.N(2), .VW(10)) u_dut (.i_clk(i_clk),
        .i_resetn(i_resetn), .i_ce(1'b1), .i_master_clear(mclr),
        .i_chan_line(line), .i_single_step_cfg(ss), .i_chan_vector(vec),
        .i_timing(tm), .i_instr(ins), .i_halt_ff(halt),
        .i_parity_err_ff(par), .i_run_sw_sig(run),
        .o_cpu_service_call(svc), .o_int_taken(tk), .o_halt_clear(hc),
        .o_pc_xfer_inhibit(), .o_vector_load(),
        .o_vector_addr_lines(vl), .o_force_phase_seven(),
        .o_indirect_set_block(blk), .o_ack_window_pulse(),
        .o_chan_release_pulse(), .o_chan_pending(pend),
        .o_chan_active(act));

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic exp_hc(input logic h, p, r);
        return h & r & ~p;
    endfunction

    task automatic to_pulse(input logic [4:0] p);
        do begin
            @(posedge i_clk);
            #2;
        end while (pulse !== p);
    endtask

    // Runs one whole word time with the given end bit and phase.
    task automatic cyc(input logic e, input logic [2:0] p);
        en = e;
        ph = p;
        to_pulse(5'h00);
    endtask

    // Request, take at end, then acknowledge with share set to s.
    task automatic take(input int k, input logic s);
        line[k] = 1'b1;
        cyc(1'b1, 3'h0);
        chk("taken", tk, 1);
        chk("vector", vl, vec[k*10+:10]);
        line[k] = 1'b0;
        sh = s;
        cyc(1'b0, 3'h0);
        sh = 1'b0;
        chk("active", act[k], 1);
        chk("taken_clr", tk, 0);
    endtask

    initial begin
        #400000;
        failures++;
        print_verdict();
    end

    initial begin
        void'($urandom(24321));
        vec = 20'($urandom);
        repeat (5) @(posedge i_clk);
        #2;
        i_resetn = 1;
        chk("rst_flags", {pend, act, tk}, 0);
        to_pulse(5'h00);
        // Line high only outside the sampling window is ignored.
        to_pulse(5'h0e);
        line[1] = 1'b1;
        to_pulse(5'h04);
        line[1] = 1'b0;
        to_pulse(5'h00);
        cyc(1'b0, 3'h0);
        chk("no_latch", pend, 0);
        line[1] = 1'b1;
        cyc(1'b0, 3'h0);
        chk("pend1", pend, 2'b10);
        chk("svc1", svc, 1);
        chk("no_take", tk, 0);
        line[1] = 1'b1;
        cyc(1'b1, 3'h0);
        chk("taken1", tk, 1);
        for (int i = 0; i < 6; i++) begin
            {halt, par, run} = 3'($urandom);
            #1;
            chk("halt_clr", hc, exp_hc(halt, par, run));
        end
        {halt, par, run} = 3'h0;
        line[1] = 1'b0;
        sh = 1'b1;
        cyc(1'b0, 3'h0);
        sh = 1'b0;
        chk("act1", act, 2'b10);
        chk("svc_off", svc, 0);
        take(0, 1'b0);
        chk("nested", act, 2'b11);
        // Two indirect branches unwind the nest one level at a time.
        ind = 1'b1;
        op = PIS_OP_UNCOND_BRANCH;
        cyc(1'b0, PIS_PH_ZERO);
        chk("rel_hi", {pend, act}, 4'b1010);
        cyc(1'b0, PIS_PH_ZERO);
        chk("rel_lo", {pend, act}, 4'b0000);
        ind = 1'b0;
        op = 6'h00;
        // Both lines before acknowledge: the higher one wins.
        vec = 20'($urandom);
        line = 2'b11;
        cyc(1'b1, 3'h0);
        chk("vec_hi", vl, vec[9:0]);
        line = 2'b00;
        cyc(1'b0, 3'h0);
        chk("ack_hi", {pend, act}, 4'b1101);
        chk("svc_wait", svc, 0);
        mclr = 1'b1;
        @(posedge i_clk);
        #2;
        mclr = 1'b0;
        chk("mclr", {pend, act, tk}, 0);
        to_pulse(5'h00);
        // Single-instruction channel: blocks the indirect set, then releases.
        ss = 2'b10;
        take(1, 1'b0);
        cyc(1'b0, PIS_PH_FOUR);
        chk("blk4", blk, 1);
        cyc(1'b0, 3'h2);
        chk("blk2", blk, 0);
        cyc(1'b1, 3'h2);
        chk("ss_rel", {pend, act}, 0);
        print_verdict();
    end
endmodule
